// File: tsfa_adc_model.sv
`timescale 1ns/100ps
module tsfa_adc_model (
    // Clock, host strobes, input level
    input  wire       clk,
    input  wire       csN,
    input  wire       rdN,
    input  wire       wrN,
    input  wire       modeOut,
    input  wire [7:0] level,
    // Converter pins
    output wire [7:0] resultBus,
    output reg        doneN = 1'b1,
    output wire       readyIn
);
    reg [7:0] latchQ = 8'h00;
    reg [3:0] cntQ = 4'h0;
    reg       runQ = 1'b0, driveQ = 1'b0, rdPrevQ = 1'b1;
    wire      rdSel = modeOut && !csN && !rdN;
    // Released bus shows the inverse of the last value
    assign resultBus = driveQ ? latchQ : ~latchQ;
    assign readyIn   = csN || modeOut || !doneN;
    always @(posedge clk)
    begin
        rdPrevQ <= rdN;
        cntQ    <= (!runQ || !wrN) ? 4'h0 : cntQ + 4'h1;
        if (csN || rdN)
            driveQ <= 1'b0;
        if (rdN && !rdPrevQ)
            doneN <= 1'b1;
        if (csN)
            runQ <= 1'b0;
        else if (modeOut ? !wrN : !rdN && rdPrevQ)
            runQ <= 1'b1;
        if (rdSel)
            driveQ <= 1'b1;
        if (runQ && (rdSel || cntQ == (modeOut ? 4'h7 : 4'hF)))
        begin
            runQ   <= 1'b0;
            latchQ <= level;
            doneN  <= 1'b0;
            driveQ <= !modeOut || rdSel;
        end
    end
endmodule // tsfa_adc_model

// File: tsfa_host.v
`timescale 1ns/100ps
`include "tsfa_regs.vh"
module tsfa_host #(
    parameter WR_CYC   = `TSFA_CYC_UP(`TSFA_WR_MIN_NS),
    parameter GAP_CYC  = `TSFA_CYC_UP(`TSFA_RD_GAP_NS),
    parameter REC_CYC  = `TSFA_CYC_UP(`TSFA_RECOVER_NS),
    parameter HOLD_CYC = `TSFA_CYC_UP(`TSFA_RD_HOLD_NS),
    parameter TO_CYC   = 2 * `TSFA_CYC_UP(`TSFA_CMP_NS) + 10
) (
    // Clock and reset
    input  wire                    clk,
    input  wire                    rst_n,
    // User command side
    input  wire                    start,
    input  wire                    modeSel,
    input  wire                    useDone,
    output reg                     busy,
    output reg                     resultValid,
    output reg  [`TSFA_DATA_W-1:0] result,
    output reg                     timeoutErr,
    // Converter pins
    output reg                     csN,
    output reg                     rdN,
    output reg                     wrN,
    output reg                     modeOut,
    input  wire [`TSFA_DATA_W-1:0] resultBus,
    input  wire                    doneN,
    input  wire                    readyIn
);
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_WRLO  = 3'h1;
    localparam [2:0] S_GAP   = 3'h2;
    localparam [2:0] S_RDLO  = 3'h3;
    localparam [2:0] S_HOLD  = 3'h4;
    localparam [2:0] S_REC   = 3'h5;
    localparam [2:0] S_ROWT  = 3'h6;

    localparam CW = 16;

    wire [`TSFA_DATA_W-1:0] busSync;
    wire                    doneSync;
    wire                    readySync;
    reg  [2:0]              state_q;
    reg  [CW-1:0]           cnt_q;
    reg                     mode_q;

    tsfa_sync #(
        .WIDTH(`TSFA_DATA_W + 2)
    ) uSync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn ({resultBus, doneN, readyIn}),
        .syncOut ({busSync, doneSync, readySync})
    );

    function [CW-1:0] cyc;
        input integer n;
        begin
            cyc = n[CW-1:0];
        end
    endfunction

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q     <= S_IDLE;
            cnt_q       <= {CW{1'b0}};
            mode_q      <= `TSFA_MODE_RD;
            busy        <= 1'b0;
            resultValid <= 1'b0;
            result      <= `TSFA_RESULT_RST;
            timeoutErr  <= 1'b0;
            csN         <= 1'b1;
            rdN         <= 1'b1;
            wrN         <= 1'b1;
            modeOut     <= `TSFA_MODE_RD;
        end
        else
        begin
            resultValid <= 1'b0;
            cnt_q       <= cnt_q + cyc(1);
            case (state_q)
                S_IDLE:
                begin
                    if (start)
                    begin
                        mode_q     <= modeSel;
                        modeOut    <= modeSel;
                        busy       <= 1'b1;
                        timeoutErr <= 1'b0;
                        csN        <= 1'b0;
                        cnt_q      <= {CW{1'b0}};
                        if (modeSel == `TSFA_MODE_WRRD)
                        begin
                            wrN     <= 1'b0;
                            state_q <= S_WRLO;
                        end
                        else
                        begin
                            rdN     <= 1'b0;
                            state_q <= S_ROWT;
                        end
                    end
                end
                S_WRLO:
                begin
                    // Write low long enough, far below the upper limit
                    if (cnt_q >= cyc(WR_CYC - 1))
                    begin
                        wrN     <= 1'b1;
                        cnt_q   <= {CW{1'b0}};
                        state_q <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    // Minimum gap always; with useDone also wait for done
                    if (cnt_q >= cyc(GAP_CYC - 1)
                        && (!useDone || !doneSync))
                    begin
                        rdN     <= 1'b0;
                        cnt_q   <= {CW{1'b0}};
                        state_q <= S_RDLO;
                    end
                    else if (cnt_q >= cyc(TO_CYC))
                    begin
                        timeoutErr <= 1'b1;
                        cnt_q      <= {CW{1'b0}};
                        csN        <= 1'b1;
                        state_q    <= S_REC;
                    end
                end
                S_ROWT:
                begin
                    // Ready high means result latched, done low confirms
                    if (readySync && !doneSync && cnt_q >= cyc(3))
                    begin
                        cnt_q   <= {CW{1'b0}};
                        state_q <= S_RDLO;
                    end
                    else if (cnt_q >= cyc(TO_CYC))
                    begin
                        timeoutErr <= 1'b1;
                        rdN        <= 1'b1;
                        csN        <= 1'b1;
                        cnt_q      <= {CW{1'b0}};
                        state_q    <= S_REC;
                    end
                end
                S_RDLO:
                begin
                    // Bus sampled HOLD_CYC after read fall, then two sync stages
                    if (cnt_q >= cyc(HOLD_CYC + 1))
                    begin
                        result      <= busSync;
                        resultValid <= 1'b1;
                        rdN         <= 1'b1;
                        cnt_q       <= {CW{1'b0}};
                        state_q     <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    csN     <= 1'b1;
                    cnt_q   <= {CW{1'b0}};
                    state_q <= S_REC;
                end
                S_REC:
                begin
                    if (cnt_q >= cyc(REC_CYC - 1))
                    begin
                        busy    <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default:
                begin
                    csN     <= 1'b1;
                    rdN     <= 1'b1;
                    wrN     <= 1'b1;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // tsfa_host

// File: tsfa_host_properties.sv
`timescale 1ns/100ps
module tsfa_host_properties (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host pins
    input wire useDone,
    input wire csN,
    input wire rdN,
    input wire wrN,
    input wire modeOut,
    input wire doneN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wr_select: assert property (!wrN |-> !csN) else $error("write unselected");
    a_wr_min: assert property ($fell(wrN) |-> !wrN [*6]) else $error("write short");
    a_wr_max: assert property ($fell(wrN) |-> ##[1:500] wrN) else $error("write long");
    a_read_gap: assert property ($rose(wrN) |-> rdN [*6]) else $error("read early");
    a_done_first: assert property ($fell(rdN) && modeOut && useDone |-> !$past(doneN, 2))
        else $error("read before done");
    a_cs_recover: assert property ($rose(csN) |-> csN [*5]) else $error("restart early");
endmodule // tsfa_host_properties
bind tsfa_host tsfa_host_properties i_props (.clk, .rst_n, .useDone, .csN, .rdN, .wrN,
    .modeOut, .doneN);

// File: tsfa_host_tb.sv
`timescale 1ns/100ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tsfa_host_tb;
    reg        clk = 1'b0, rst_n = 1'b0, start = 1'b0, modeSel = 1'b0, useDone = 1'b0;
    reg  [7:0] level = 8'h00;
    wire       busy, resultValid, timeoutErr, csN, rdN, wrN, modeOut, doneN, readyIn;
    wire [7:0] result, resultBus;
    int        bad_count = 0, n_tests = 0;
    tsfa_host i_dut (.clk, .rst_n, .start, .modeSel, .useDone, .busy, .resultValid, .result,
        .timeoutErr, .csN, .rdN, .wrN, .modeOut, .resultBus, .doneN, .readyIn);
    tsfa_adc_model i_adc (.clk, .csN, .rdN, .wrN, .modeOut, .level, .resultBus, .doneN,
        .readyIn);
    initial forever #50 clk = ~clk;
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    task automatic run_conv(input logic m, u, input logic [7:0] v);
        int i;
        @(posedge clk) start <= 1'b1;
        modeSel <= m;
        useDone <= u;
        level   <= v;
        @(posedge clk) start <= 1'b0;
        for (i = 0; i < 80 && resultValid !== 1'b1; i++)
            @(posedge clk) #1;
        `CHECK(resultValid, 1'b1)
        `CHECK(result, v)
        `CHECK(timeoutErr, 1'b0)
        repeat (7) @(posedge clk);
        #1 `CHECK(busy, 1'b0)
    endtask
    task automatic test_write_read;
        run_conv(1'b1, 1'b0, 8'hA5);
        run_conv(1'b1, 1'b1, 8'h3C);
    endtask
    task automatic test_read_only;
        run_conv(1'b0, 1'b0, 8'h00);
        run_conv(1'b0, 1'b0, 8'hF0);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_write_read();
        test_read_only();
        stop_test();
    end
endmodule // tsfa_host_tb

// File: tsfa_regs.vh
`ifndef TSFA_REGS_VH
`define TSFA_REGS_VH

// Timing figures in ns, clock period in ns
`define TSFA_CLK_NS      100
`define TSFA_WR_MIN_NS   600
`define TSFA_RD_GAP_NS   600
`define TSFA_CMP_NS      800
`define TSFA_RECOVER_NS  500
`define TSFA_WR_MAX_NS   50000
`define TSFA_RD_HOLD_NS  300

// Least times round up to whole cycles
`define TSFA_CYC_UP(ns) (((ns) + `TSFA_CLK_NS - 1) / `TSFA_CLK_NS)

// Mode strap values
`define TSFA_MODE_RD     1'b0
`define TSFA_MODE_WRRD   1'b1

// Result layout
`define TSFA_DATA_W      8
`define TSFA_RESULT_RST  8'h00

`endif

// File: tsfa_sync.v
`timescale 1ns/100ps
module tsfa_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Asynchronous inputs and their synchronised copy
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q  <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // tsfa_sync
